// ### rtl/cpwm_output_control.sv
// complementary three-phase pwm output control with apb registers
//
// Summary of operation
// (RULE_01) buffer registers writable at any time
// (RULE_02) stopped sub-counter: buffers reach temporaries at once
// (RULE_03) running sub-counter: transfer deferred until halt
// (RULE_04) temporaries load compares at crest/trough/both
// (RULE_05) all five transfer together after last duty
// (RULE_06) software always ends update with last duty
// (RULE_07) outputs inactive until lagging counter passes dead
// (RULE_08) compare and temporary both matched while running
// (RULE_09) turn-off beats turn-on, early ons ignored
// (RULE_10) off from leading, on from lagging counter
// (RULE_11) negative off first half, positive off second
// (RULE_12) zero duty gives positive always on
// (RULE_13) duty equal cycle limit gives positive off
// (RULE_14) coincident on and off are both ignored
// (RULE_15) toggle pin flips at crest and lag zero
// (RULE_16) synchronous clear from other channel resets counters
// (RULE_17) hall edges switch phase states
// (RULE_18) software state bits switch phases
// (RULE_19) chop bits select pwm or steady on level
// (RULE_20) level select independent of chop bits
// (RULE_21) conversion start request at cycle-limit match
// (RULE_22) protect bit blocks mode, control, dead time and counter access
// (RULE_23) main counter between dead time and limit
// (RULE_24) lagging counter between zero and half cycle
// (RULE_25) sub-counter wraps at limit and zero
// (RULE_26) emergency or clock stop forces high impedance
// (RULE_27) high impedance held until software re-arms
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cpwm_output_control #(
  parameter int CW = 16
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  emergencyIn,
  input  wire logic        clockStopped,
  input  wire logic        syncClear,
  input  wire logic [2:0]  hallIn,
  output logic [5:0]       pwmOut,
  output logic [5:0]       pwmOe_b,
  output logic             togglePin,
  output logic             adcStart
);
  cpwm_pkg::ctrl_t      ctrl_q;
  cpwm_pkg::outctl_t    outc_q;
  cpwm_pkg::cnt_state_t st_q;
  logic          protect_q;
  logic [CW-1:0] dead_q;
  logic [CW-1:0] buf_q [cpwm_pkg::NBUF];
  logic [CW-1:0] tmp_q [cpwm_pkg::NBUF];
  logic [CW-1:0] cmp_q [cpwm_pkg::NBUF];
  logic [CW-1:0] mainCnt_q;
  logic [CW-1:0] lagCnt_q;
  logic [CW-1:0] subCnt_q;
  logic          subRun_q;
  logic          subUp_q;
  logic          pend_q;
  logic          modePrev_q;
  logic          startOk_q;
  logic          hiz_q;
  logic [2:0]    hallPrev_q;
  logic [2:0]    hallState_q;
  logic [31:0]   rdVal;
  logic          mapped;
  logic          prot;
  logic [2:0]    posOn;
  logic [2:0]    negOn;
  logic [5:0]    act;

  wire           access  = psel & penable & pready;
  wire           wr      = access & pwrite & mapped & !prot;
  wire           lastWr  = wr && paddr == cpwm_pkg::ADDR_DUTY2;
  wire           rearmWr = wr && paddr == cpwm_pkg::ADDR_REARM && pwdata[0];
  wire           entry   = ctrl_q.modeEnable & !modePrev_q;
  wire           running = ctrl_q.modeEnable & ctrl_q.run;
  wire           xfer    = pend_q & !subRun_q;
  wire [CW-1:0]  lim     = cmp_q[cpwm_pkg::IDX_CYC];
  wire [CW-1:0]  half    = cmp_q[cpwm_pkg::IDX_HALF];
  wire           crest   = st_q == cpwm_pkg::ST_UP && mainCnt_q == lim;
  wire           trough  = st_q == cpwm_pkg::ST_DOWN && mainCnt_q == dead_q;
  wire           lagZero = st_q == cpwm_pkg::ST_DOWN && lagCnt_q == '0;
  wire           updNow  = (crest & ctrl_q.updMode[0]) | (trough & ctrl_q.updMode[1]);
  wire           syncClr = running & ctrl_q.syncEnable & ctrl_q.clearSel == cpwm_pkg::CLR_SYNC & syncClear;
  wire           emerg   = (|emergencyIn) | clockStopped;
  wire [2:0]     softSt  = {outc_q.wState, outc_q.vState, outc_q.uState};
  wire [2:0]     phSel   = outc_q.switchSource ? softSt : hallState_q; // RULE_18

  // address decode; protected registers refuse both directions
  always_comb
  begin
    rdVal  = '0;
    mapped = 1'b1;
    prot   = 1'b0;
    case (paddr)
      cpwm_pkg::ADDR_CTRL:
      begin
        rdVal = 32'(ctrl_q);
        prot  = protect_q; // RULE_22
      end
      cpwm_pkg::ADDR_OUTC:
      begin
        rdVal = 32'(outc_q);
        prot  = protect_q; // RULE_22
      end
      cpwm_pkg::ADDR_DEAD:
      begin
        rdVal = 32'(dead_q);
        prot  = protect_q;
      end
      cpwm_pkg::ADDR_MAIN:
      begin
        rdVal = 32'(mainCnt_q);
        prot  = protect_q;
      end
      cpwm_pkg::ADDR_LAG:
      begin
        rdVal = 32'(lagCnt_q);
        prot  = protect_q;
      end
      cpwm_pkg::ADDR_SUB:
      begin
        rdVal = 32'(subCnt_q);
        prot  = protect_q;
      end
      cpwm_pkg::ADDR_DUTY0:  rdVal = 32'(buf_q[0]);
      cpwm_pkg::ADDR_DUTY1:  rdVal = 32'(buf_q[1]);
      cpwm_pkg::ADDR_DUTY2:  rdVal = 32'(buf_q[2]);
      cpwm_pkg::ADDR_CYC:    rdVal = 32'(buf_q[cpwm_pkg::IDX_CYC]);
      cpwm_pkg::ADDR_HALF:   rdVal = 32'(buf_q[cpwm_pkg::IDX_HALF]);
      cpwm_pkg::ADDR_BUSCTL: rdVal = 32'(protect_q) << cpwm_pkg::PROTECT_BIT;
      cpwm_pkg::ADDR_STAT:   rdVal = 32'({hiz_q, startOk_q, subRun_q, pend_q, st_q, phSel});
      cpwm_pkg::ADDR_REARM:  rdVal = '0;
      default:               mapped = 1'b0;
    endcase
  end

  // one wait state: pready rises the cycle after penable
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready <= psel & penable & !pready;
      if (psel && penable && !pready)
      begin
        pslverr <= !mapped | prot;
        prdata  <= (mapped && !prot) ? rdVal : '0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ctrl_q    <= cpwm_pkg::CTRL_RST;
      outc_q    <= cpwm_pkg::OUTC_RST;
      dead_q    <= '0;
      protect_q <= 1'b0;
    end
    else if (wr)
    begin
      case (paddr)
        cpwm_pkg::ADDR_CTRL:   ctrl_q    <= cpwm_pkg::ctrl_t'(pwdata[9:0]);
        cpwm_pkg::ADDR_OUTC:   outc_q    <= cpwm_pkg::outctl_t'(pwdata[8:0]);
        cpwm_pkg::ADDR_DEAD:   dead_q    <= pwdata[CW-1:0];
        cpwm_pkg::ADDR_BUSCTL: protect_q <= pwdata[cpwm_pkg::PROTECT_BIT]; // RULE_22
        default:               protect_q <= protect_q;
      endcase
    end
  end

  // buffers never protected
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < cpwm_pkg::NBUF; i++)
        buf_q[i] <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        cpwm_pkg::ADDR_DUTY0: buf_q[0] <= pwdata[CW-1:0]; // RULE_01
        cpwm_pkg::ADDR_DUTY1: buf_q[1] <= pwdata[CW-1:0];
        cpwm_pkg::ADDR_DUTY2: buf_q[2] <= pwdata[CW-1:0];
        cpwm_pkg::ADDR_CYC:   buf_q[cpwm_pkg::IDX_CYC] <= pwdata[CW-1:0];
        cpwm_pkg::ADDR_HALF:  buf_q[cpwm_pkg::IDX_HALF] <= pwdata[CW-1:0];
        default:              buf_q[0] <= buf_q[0];
      endcase
    end
  end

  // last-duty write arms transfer; a new arm beats the clear
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      pend_q <= 1'b0;
    else
      pend_q <= lastWr | (pend_q & !xfer); // RULE_05 RULE_06
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < cpwm_pkg::NBUF; i++)
        tmp_q[i] <= '0;
    end
    else if (xfer)
    begin
      // held off while the sub-counter runs
      for (int i = 0; i < cpwm_pkg::NBUF; i++)
        tmp_q[i] <= buf_q[i]; // RULE_02 RULE_03 RULE_05
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < cpwm_pkg::NBUF; i++)
        cmp_q[i] <= '0;
    end
    else if (entry)
    begin
      for (int i = 0; i < cpwm_pkg::NBUF; i++)
        cmp_q[i] <= buf_q[i];
    end
    else if (updNow)
    begin
      for (int i = 0; i < cpwm_pkg::NBUF; i++)
        cmp_q[i] <= tmp_q[i]; // RULE_04
    end
  end

  // main and lagging counters move in lockstep
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st_q      <= cpwm_pkg::ST_IDLE;
      mainCnt_q <= '0;
      lagCnt_q  <= '0;
    end
    else if (!running || syncClr)
    begin
      st_q      <= syncClr ? cpwm_pkg::ST_UP : cpwm_pkg::ST_IDLE; // RULE_16
      mainCnt_q <= dead_q;
      lagCnt_q  <= '0;
    end
    else
    begin
      case (st_q)
        cpwm_pkg::ST_UP:
        begin
          st_q      <= (mainCnt_q == lim) ? cpwm_pkg::ST_DOWN : cpwm_pkg::ST_UP;
          mainCnt_q <= (mainCnt_q == lim) ? mainCnt_q - 1'b1 : mainCnt_q + 1'b1; // RULE_23
          lagCnt_q  <= (lagCnt_q == half) ? lagCnt_q - 1'b1 : lagCnt_q + 1'b1; // RULE_24
        end
        cpwm_pkg::ST_DOWN:
        begin
          st_q      <= (mainCnt_q == dead_q) ? cpwm_pkg::ST_UP : cpwm_pkg::ST_DOWN;
          mainCnt_q <= (mainCnt_q == dead_q) ? mainCnt_q + 1'b1 : mainCnt_q - 1'b1; // RULE_23
          lagCnt_q  <= (lagCnt_q == '0) ? lagCnt_q + 1'b1 : lagCnt_q - 1'b1; // RULE_24
        end
        default:
        begin
          st_q      <= cpwm_pkg::ST_UP;
          mainCnt_q <= dead_q;
          lagCnt_q  <= '0;
        end
      endcase
    end
  end

  // sub-counter covers the crest and trough windows only
  always_ff @(posedge mclk)
  begin
    if (!rst_b || !running || syncClr)
    begin
      subRun_q <= 1'b0;
      subUp_q  <= 1'b0;
      subCnt_q <= '0;
    end
    else if (st_q == cpwm_pkg::ST_UP && mainCnt_q == half)
    begin
      subRun_q <= 1'b1;
      subUp_q  <= 1'b1;
      subCnt_q <= half;
    end
    else if (st_q == cpwm_pkg::ST_DOWN && lagCnt_q == dead_q)
    begin
      subRun_q <= 1'b1;
      subUp_q  <= 1'b0;
      subCnt_q <= dead_q;
    end
    else if ((st_q == cpwm_pkg::ST_DOWN && mainCnt_q == half) || (st_q == cpwm_pkg::ST_UP && lagCnt_q == dead_q))
      subRun_q <= 1'b0;
    else if (subRun_q)
    begin
      if (subUp_q)
        subCnt_q <= (subCnt_q == lim) ? '0 : subCnt_q + 1'b1; // RULE_25
      else
        subCnt_q <= (subCnt_q == '0) ? lim : subCnt_q - 1'b1; // RULE_25
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      modePrev_q <= 1'b0;
      startOk_q  <= 1'b0;
    end
    else
    begin
      modePrev_q <= ctrl_q.modeEnable;
      if (!ctrl_q.modeEnable || entry)
        startOk_q <= 1'b0;
      else if (lagCnt_q > dead_q)
        startOk_q <= 1'b1; // RULE_07
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gPhase
      wire leadM = mainCnt_q == cmp_q[g] || (subRun_q && mainCnt_q == tmp_q[g]); // RULE_08 RULE_10
      wire lagM  = lagCnt_q == cmp_q[g] || (subRun_q && lagCnt_q == tmp_q[g]); // RULE_08
      cpwm_phase_arbiter uArb (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .enable    (running & startOk_q),
        .firstHalf (st_q == cpwm_pkg::ST_UP), // RULE_11
        .halfFlip  (crest | trough),
        .leadMatch (leadM),
        .lagMatch  (lagM),
        .dutyZero  (cmp_q[g] == '0), // RULE_12
        .dutyFull  (cmp_q[g] == lim), // RULE_13
        .posOn     (posOn[g]),
        .negOn     (negOn[g])
      );
      wire hiOn = phSel[g] & !phSel[(g + 1) % 3];
      wire loOn = !phSel[g] & phSel[(g + 1) % 3];
      // on phases chop or stay steady; off phases stay inactive
      assign act[g]     = !outc_q.motorGate ? posOn[g] : hiOn & (outc_q.chopP ? posOn[g] : 1'b1); // RULE_19
      assign act[g + 3] = !outc_q.motorGate ? negOn[g] : loOn & (outc_q.chopN ? negOn[g] : 1'b1); // RULE_19
    end
  endgenerate

  // hall state latched on any edge; inputs already synchronous
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      hallPrev_q  <= '0;
      hallState_q <= '0;
    end
    else
    begin
      hallPrev_q <= hallIn;
      if (hallIn != hallPrev_q)
        hallState_q <= hallIn; // RULE_17
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      pwmOut <= '0;
    else if (!ctrl_q.modeEnable || !startOk_q)
      pwmOut <= {{3{!outc_q.negLevel}}, {3{!outc_q.posLevel}}}; // RULE_07
    else
      pwmOut <= act ~^ {{3{outc_q.negLevel}}, {3{outc_q.posLevel}}}; // RULE_20
  end

  // set beats re-arm so an emergency cannot slip past
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      hiz_q   <= 1'b0;
      pwmOe_b <= '0;
    end
    else
    begin
      hiz_q   <= emerg | (hiz_q & !rearmWr); // RULE_27
      pwmOe_b <= {6{emerg | (hiz_q & !rearmWr)}}; // RULE_26
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b || !ctrl_q.modeEnable)
      togglePin <= cpwm_pkg::TOGGLE_INIT;
    else if (ctrl_q.toggleEnable && running && (crest || lagZero))
      togglePin <= !togglePin; // RULE_15
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      adcStart <= 1'b0;
    else
      adcStart <= running & crest & ctrl_q.convTrigEnable; // RULE_21
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_run_block: assert property (subRun_q && !entry |=> tmp_q[4] == $past(tmp_q[4])) // RULE_03
    else $error("temporary changed while sub-counter runs");
  a_group_xfer: assert property (xfer |=> tmp_q[0] == $past(buf_q[0]) && tmp_q[4] == $past(buf_q[4])) // RULE_05
    else $error("buffers not moved together");
  a_cmp_update: assert property (updNow && !entry |=> cmp_q[1] == $past(tmp_q[1])) // RULE_04
    else $error("compare not loaded at update instant");
  a_initial_level: assert property (ctrl_q.modeEnable && !startOk_q |=> pwmOut[0] == !$past(outc_q.posLevel)) // RULE_07
    else $error("initial output not inactive");
  a_toggle_flip: assert property (ctrl_q.toggleEnable && running && (crest || lagZero)
    |=> togglePin != $past(togglePin)) // RULE_15
    else $error("toggle pin did not flip");
  a_adc_pulse: assert property (running && crest && ctrl_q.convTrigEnable |=> adcStart ##1 !adcStart) // RULE_21
    else $error("conversion request missing");
  a_sync_clear: assert property (syncClr |=> mainCnt_q == $past(dead_q) && lagCnt_q == '0 && !subRun_q) // RULE_16
    else $error("counters not cleared together");
  a_hiz_force: assert property (emerg |=> pwmOe_b == 6'h3f && hiz_q) // RULE_26
    else $error("emergency did not release outputs");
  a_hiz_hold: assert property (hiz_q && !rearmWr |=> hiz_q && pwmOe_b == 6'h3f) // RULE_27
    else $error("high impedance dropped without re-arm");
  a_protect_ctrl: assert property (access && pwrite && protect_q && paddr == cpwm_pkg::ADDR_CTRL
    |=> $stable(ctrl_q) && pslverr == $past(pslverr)) // RULE_22
    else $error("protected write took effect");
endmodule : cpwm_output_control

// ### inc/cpwm_pkg.sv
// register map, field layouts and reset values of the complementary pwm output block
package cpwm_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OUTC   = 8'h04;
  localparam logic [7:0] ADDR_DEAD   = 8'h08;
  localparam logic [7:0] ADDR_CYC    = 8'h0c;
  localparam logic [7:0] ADDR_HALF   = 8'h10;
  localparam logic [7:0] ADDR_DUTY0  = 8'h14;
  localparam logic [7:0] ADDR_DUTY1  = 8'h18;
  localparam logic [7:0] ADDR_DUTY2  = 8'h1c;
  localparam logic [7:0] ADDR_BUSCTL = 8'h20;
  localparam logic [7:0] ADDR_MAIN   = 8'h24;
  localparam logic [7:0] ADDR_LAG    = 8'h28;
  localparam logic [7:0] ADDR_SUB    = 8'h2c;
  localparam logic [7:0] ADDR_STAT   = 8'h30;
  localparam logic [7:0] ADDR_REARM  = 8'h34;
  localparam int         PROTECT_BIT = 13;
  localparam int         NBUF        = 5;
  localparam int         IDX_CYC     = 3;
  localparam int         IDX_HALF    = 4;
  localparam logic [2:0] CLR_SYNC    = 3'h3;
  localparam logic       TOGGLE_INIT = 1'b1;

  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_UP = 2'h1, ST_DOWN = 2'h3} cnt_state_t;

  typedef struct packed {
    logic [2:0] clearSel;
    logic       syncEnable;
    logic       convTrigEnable;
    logic       toggleEnable;
    logic [1:0] updMode;
    logic       run;
    logic       modeEnable;
  } ctrl_t;

  typedef struct packed {
    logic motorGate;
    logic chopN;
    logic chopP;
    logic wState;
    logic vState;
    logic uState;
    logic switchSource;
    logic posLevel;
    logic negLevel;
  } outctl_t;

  localparam ctrl_t   CTRL_RST = ctrl_t'(10'h000);
  localparam outctl_t OUTC_RST = outctl_t'(9'h003);
endpackage : cpwm_pkg

// ### rtl/cpwm_phase_arbiter.sv
// turn-on / turn-off arbitration of one complementary output pair
`timescale 1ns/1ps
module cpwm_phase_arbiter (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic firstHalf,
  input  wire logic halfFlip,
  input  wire logic leadMatch,
  input  wire logic lagMatch,
  input  wire logic dutyZero,
  input  wire logic dutyFull,
  output logic      posOn,
  output logic      negOn
);
  logic offSeen_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_b || !enable)
    begin
      posOn     <= 1'b0;
      negOn     <= 1'b0;
      offSeen_q <= 1'b0;
    end
    else if (dutyZero)
    begin
      posOn <= 1'b1; // RULE_12
      negOn <= 1'b0;
    end
    else if (dutyFull)
    begin
      posOn <= 1'b0; // RULE_13
      negOn <= 1'b1;
    end
    else if (halfFlip)
      offSeen_q <= 1'b0;
    else if (leadMatch && !lagMatch)
    begin
      // off edge from leading counter wins the half
      offSeen_q <= 1'b1; // RULE_09 RULE_11 RULE_14
      if (firstHalf)
        negOn <= 1'b0; // RULE_10
      else
        posOn <= 1'b0;
    end
    else if (lagMatch && !leadMatch && offSeen_q)
    begin
      // on edge from lagging counter only after this half's off edge
      if (firstHalf)
        posOn <= 1'b1; // RULE_10
      else
        negOn <= 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_no_overlap: assert property (!(posOn && negOn)) // RULE_09
    else $error("positive and negative on together");
  a_coincide_hold: assert property (enable && !dutyZero && !dutyFull && !halfFlip && leadMatch && lagMatch
    && $past(enable) |=> posOn == $past(posOn) && negOn == $past(negOn)) // RULE_14
    else $error("coincident matches changed output");
  a_zero_duty: assert property (enable && dutyZero |=> posOn && !negOn) // RULE_12
    else $error("zero duty not full on");
endmodule : cpwm_phase_arbiter

// ### tb/cpwm_bridge_model.sv
// inverter bridge model: leg levels and shoot-through watch
`timescale 1ns/1ps
module cpwm_bridge_model (
  input  wire logic       mclk,
  input  wire logic [5:0] pwmOut,
  input  wire logic [5:0] pwmOe_b,
  output int              shoot,
  output logic [2:0]      leg
);
  int         nShort = 0;
  logic [2:0] legLvl = 3'h0;

  assign shoot = nShort;
  assign leg   = legLvl;
  always @(posedge mclk)
  begin
    for (int k = 0; k < 3; k++)
    begin
      // gates taken as active high, both switches of a leg on is a short
      if (!pwmOe_b[k] && !pwmOe_b[k+3] && pwmOut[k] && pwmOut[k+3])
        nShort = nShort + 1;
      // a released leg floats: show a changing level so a stale one never passes
      legLvl[k] <= (pwmOe_b[k] | pwmOe_b[k+3]) ? ~legLvl[k] : pwmOut[k];
    end
  end
endmodule : cpwm_bridge_model

// ### tb/tb_cpwm_output_control.sv
// self-checking bench of the complementary pwm output block
`timescale 1ns/1ps
module tb_cpwm_output_control;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  emergencyIn = 4'h0;
  logic        clockStopped = 1'b0;
  logic        syncClear = 1'b0;
  logic [2:0]  hallIn = 3'h0;
  logic [5:0]  pwmOut;
  logic [5:0]  pwmOe_b;
  logic        togglePin;
  logic        adcStart;
  int          shoot;
  logic [2:0]  leg;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 32'h66852d1f;
  logic [31:0] rd;
  logic        er;
  int          tog, adc, p0, p1;
  logic        tp;
  logic [31:0] d2;
  localparam logic [31:0] DEAD = 32'h4;
  localparam logic [31:0] HALF = 32'h14;
  localparam logic [31:0] CYC  = 32'h18;

  cpwm_output_control #(.CW(16)) i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .emergencyIn(emergencyIn), .clockStopped(clockStopped), .syncClear(syncClear), .hallIn(hallIn),
    .pwmOut(pwmOut), .pwmOe_b(pwmOe_b), .togglePin(togglePin), .adcStart(adcStart));
  cpwm_bridge_model i_bridge (.mclk(mclk), .pwmOut(pwmOut), .pwmOe_b(pwmOe_b), .shoot(shoot), .leg(leg));

  always #12.5 mclk = ~mclk;

  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask : wrap_up

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask : chk

  task chk1(input logic got, input logic exp);
  begin
    chk({31'h0, got}, {31'h0, exp});
  end
  endtask : chk1

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask : apb

  task watch(input int n);
  begin
    tog = 0;
    adc = 0;
    p0 = 0;
    p1 = 0;
    tp = togglePin;
    repeat (n)
    begin
      @(negedge mclk);
      if (togglePin !== tp) tog++;
      tp = togglePin;
      adc += (adcStart === 1'b1);
      p0 += (pwmOut[0] === 1'b1);
      p1 += (pwmOut[1] === 1'b1);
    end
  end
  endtask : watch

  function automatic logic [31:0] duty();
    // kept below the half cycle so the lagging counter reaches both edges
    return DEAD + 32'h1 + ({$random(seed)} % (HALF - DEAD - 32'h1));
  endfunction : duty

  initial
  begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk1(togglePin, cpwm_pkg::TOGGLE_INIT);
    chk1(adcStart, 1'b0);
    apb(1'b0, cpwm_pkg::ADDR_OUTC, 32'h0);
    chk(rd, 32'(cpwm_pkg::OUTC_RST));
    apb(1'b0, 8'h3c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("reset and map done");
    apb(1'b1, cpwm_pkg::ADDR_BUSCTL, 32'h1 << cpwm_pkg::PROTECT_BIT);
    apb(1'b1, cpwm_pkg::ADDR_CTRL, 32'h1);
    chk1(er, 1'b1);
    apb(1'b1, cpwm_pkg::ADDR_DUTY0, duty());
    chk1(er, 1'b0);
    apb(1'b1, cpwm_pkg::ADDR_BUSCTL, 32'h0);
    $display("protect done");
    apb(1'b1, cpwm_pkg::ADDR_DEAD, DEAD);
    apb(1'b1, cpwm_pkg::ADDR_CYC, CYC);
    apb(1'b1, cpwm_pkg::ADDR_HALF, HALF);
    apb(1'b1, cpwm_pkg::ADDR_DUTY0, duty());
    apb(1'b1, cpwm_pkg::ADDR_DUTY1, duty());
    d2 = duty();
    apb(1'b1, cpwm_pkg::ADDR_DUTY2, d2);
    apb(1'b1, cpwm_pkg::ADDR_CTRL, 32'h1);
    watch(4);
    chk({pwmOe_b, pwmOut}, 32'h0);
    apb(1'b1, cpwm_pkg::ADDR_CTRL, 32'h3f);
    watch(200);
    chk1(tog >= 8 && tog <= 12, 1'b1);
    chk1(adc >= 4 && adc <= 6, 1'b1);
    chk1(p0 > 0 && p0 < 200, 1'b1);
    $display("running pwm done");
    apb(1'b1, cpwm_pkg::ADDR_DUTY0, 32'h0);
    apb(1'b1, cpwm_pkg::ADDR_DUTY1, CYC);
    apb(1'b1, cpwm_pkg::ADDR_DUTY2, d2);
    repeat (120) @(posedge mclk);
    watch(80);
    chk(p0, 32'd80);
    chk(p1, 32'd0);
    chk1(leg[0], 1'b1);
    $display("duty extremes done");
    apb(1'b1, cpwm_pkg::ADDR_OUTC, 32'h10f);
    watch(4);
    chk(pwmOut, 32'h21);
    apb(1'b1, cpwm_pkg::ADDR_OUTC, 32'h1d7);
    watch(4);
    chk(pwmOut, 32'h0);
    hallIn <= 3'h3;
    apb(1'b1, cpwm_pkg::ADDR_OUTC, 32'h103);
    watch(4);
    chk(pwmOut, 32'h22);
    apb(1'b1, cpwm_pkg::ADDR_OUTC, 32'h3);
    $display("motor gate done");
    apb(1'b1, cpwm_pkg::ADDR_CTRL, 32'h1ff);
    repeat (3 + {$random(seed)} % 9) @(posedge mclk);
    syncClear <= 1'b1;
    @(posedge mclk);
    syncClear <= 1'b0;
    apb(1'b0, cpwm_pkg::ADDR_LAG, 32'h0);
    chk1(rd < 32'h8, 1'b1);
    $display("sync clear done");
    for (int s = 0; s < 2; s++)
    begin
      @(posedge mclk);
      if (s == 0)
        emergencyIn <= 4'h1 << ({$random(seed)} % 4);
      else
        clockStopped <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      chk(pwmOe_b, 32'h3f);
      @(posedge mclk);
      emergencyIn <= 4'h0;
      clockStopped <= 1'b0;
      watch(10);
      chk(pwmOe_b, 32'h3f);
      apb(1'b1, cpwm_pkg::ADDR_REARM, 32'h1);
      watch(2);
      chk(pwmOe_b, 32'h0);
    end
    $display("output protection done");
    chk(shoot, 32'h0);
    wrap_up;
  end
endmodule : tb_cpwm_output_control
